// [src/csa_top.sv]
// Charger status register with open-drain host alert
`timescale 1ns/100ps
`default_nettype none
`include "csa_params.svh"

module csa_top
  import csa_pkg::*;
#(
  parameter int unsigned DEGLITCH_CYCLES = `CSA_DEGLITCH_CYCLES
)(
  // System clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Charger condition pins
  input  wire logic por_done,
  input  wire logic adapter_present,
  input  wire logic drive_regulator_rail,
  input  wire logic charger_running,
  input  wire logic voltage_loop_active,
  // Control bit from the control register logic
  input  wire logic charge_inhibit,
  // Link pins
  input  wire logic link_clk,
  input  wire logic link_frame_n,
  input  wire logic sda_in,
  output var  logic sda_out,
  output var  logic sda_oe,
  // Alert pin
  input  wire logic alert_in,
  output var  logic alert_out,
  output var  logic alert_oe
);

  csa_link_if lnk ();

  csa_link_port u_link (
    .link_clk     (link_clk),
    .link_frame_n (link_frame_n),
    .sda_in       (sda_in),
    .sda_out      (sda_out),
    .sda_oe       (sda_oe),
    .lnk          (lnk.link)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_s1, pin_s2;
  logic       ack_s1, ack_s2, done_s1, done_s2, done_s3;
  logic       alert_in_s1, alert_in_s2;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1      <= 5'h00;
      pin_s2      <= 5'h00;
      ack_s1      <= 1'b0;
      ack_s2      <= 1'b0;
      done_s1     <= 1'b0;
      done_s2     <= 1'b0;
      done_s3     <= 1'b0;
      alert_in_s1 <= 1'b1;
      alert_in_s2 <= 1'b1;
    end else begin
      pin_s1      <= {voltage_loop_active, charger_running, drive_regulator_rail,
                      adapter_present, por_done};
      pin_s2      <= pin_s1;
      ack_s1      <= lnk.shadow_ack_tgl;
      ack_s2      <= ack_s1;
      done_s1     <= lnk.read_done_tgl;
      done_s2     <= done_s1;
      done_s3     <= done_s2;
      alert_in_s1 <= alert_in;
      alert_in_s2 <= alert_in_s1;
    end
  end

  logic read_done;
  assign read_done = done_s2 ^ done_s3;

  // ----------------------------------------------------------------
  // Raw flag conditions
  // ----------------------------------------------------------------
  logic raw_not_ready, raw_not_on, raw_vloop_idle;
  assign raw_not_ready  = ~(pin_s2[0] & pin_s2[1] & pin_s2[2]);
  assign raw_not_on     = ~pin_s2[3] | charge_inhibit;
  assign raw_vloop_idle = raw_not_on | ~pin_s2[4];

  // ----------------------------------------------------------------
  // Deglitch filters: index 0 not-ready, index 1 voltage-idle
  // ----------------------------------------------------------------
  localparam logic [`CSA_CNT_WIDTH-1:0] DG_LAST = `CSA_CNT_WIDTH'(DEGLITCH_CYCLES - 1);

  logic [`CSA_CNT_WIDTH-1:0] dg_cnt [2];
  logic [`CSA_CNT_WIDTH-1:0] next_dg_cnt [2];
  logic [1:0]                dg_out, next_dg_out, dg_raw;
  assign dg_raw = {raw_vloop_idle, raw_not_ready};

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_dg_cnt[i] = '0;
      next_dg_out[i] = dg_out[i];
      if (dg_raw[i] != dg_out[i]) begin
        if (dg_cnt[i] >= DG_LAST) begin
          next_dg_out[i] = dg_raw[i];
        end else begin
          next_dg_cnt[i] = dg_cnt[i] + `CSA_CNT_WIDTH'(1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dg_cnt[0] <= '0;
      dg_cnt[1] <= '0;
      dg_out    <= 2'b11;
    end else begin
      dg_cnt[0] <= next_dg_cnt[0];
      dg_cnt[1] <= next_dg_cnt[1];
      dg_out    <= next_dg_out;
    end
  end

  // ----------------------------------------------------------------
  // Status register, shadow publish and alert
  // ----------------------------------------------------------------
  csa_word_type flags, next_flags, shadow, next_shadow;
  logic         shadow_tgl, next_shadow_tgl;
  logic         alert_pend, next_alert_pend;
  logic         link_rst;
  logic         flag_change, link_current;

  always_comb begin
    next_flags = 16'h0000;
    next_flags[`CSA_BIT_NOT_READY]  = dg_out[0];
    next_flags[`CSA_BIT_NOT_ON]     = raw_not_on;
    next_flags[`CSA_BIT_VLOOP_IDLE] = dg_out[1];
    flag_change  = next_flags != flags;
    link_current = (shadow_tgl == ack_s2) && (shadow == flags);
    next_shadow     = shadow;
    next_shadow_tgl = shadow_tgl;
    if (shadow_tgl == ack_s2 && shadow != flags) begin
      next_shadow     = flags;
      next_shadow_tgl = ~shadow_tgl;
    end
    next_alert_pend = alert_pend;
    if (flag_change) begin
      next_alert_pend = 1'b1;
    end else if (read_done && link_current) begin
      next_alert_pend = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags      <= `CSA_STATUS_RESET;
      shadow     <= `CSA_STATUS_RESET;
      shadow_tgl <= 1'b0;
      alert_pend <= 1'b0;
      alert_oe   <= 1'b0;
      alert_out  <= 1'b0;
      link_rst   <= 1'b1;
    end else begin
      flags      <= next_flags;
      shadow     <= next_shadow;
      shadow_tgl <= next_shadow_tgl;
      alert_pend <= next_alert_pend;
      alert_oe   <= next_alert_pend;
      alert_out  <= 1'b0;
      link_rst   <= 1'b0;
    end
  end

  assign lnk.shadow     = shadow;
  assign lnk.shadow_tgl = shadow_tgl;
  assign lnk.link_rst   = link_rst;

endmodule : csa_top

`default_nettype wire

// [src/csa_params.svh]
// Constants for the charger status and alert block
//
// Behaviour
// - Flags follow system conditions; not-ready and voltage-idle pass an 8 ms deglitch.
// - Any status flag change pulls the open-drain alert low.
// - Alert stays low until the host completes a status read of the current flags, then released.
// - Status sits at command 0x13, read-only; host writes change nothing.
// - Bit 0 is not-ready-to-charge, 1 after power-up.
// - Not-ready clears only with reset done, adapter present, drive rail ready.
// - Bit 1 is charger-not-on, 1 after power-up.
// - Voltage-loop-idle reads 1 after power-up and while charger is off.
// - Voltage-loop-idle sits at bit 2, 0 while the voltage loop regulates.
// - Charge-inhibit control bit turns charger off, shown in bit 1.
`ifndef CSA_PARAMS_SVH
`define CSA_PARAMS_SVH

`define CSA_STATUS_CMD      8'h13
`define CSA_BIT_NOT_READY   0
`define CSA_BIT_NOT_ON      1
`define CSA_BIT_VLOOP_IDLE  2
`define CSA_STATUS_RESET    16'h0007
`define CSA_DEGLITCH_MS     8
`define CSA_SYS_CLK_NS      8
`define CSA_DEGLITCH_CYCLES (`CSA_DEGLITCH_MS * 1000000 / `CSA_SYS_CLK_NS)
`define CSA_CNT_WIDTH       20
`define CSA_HDR_LAST        5'h08
`define CSA_DATA_LAST       5'h0f

`endif

// [src/csa_pkg.sv]
// Types for the charger status and alert block
package csa_pkg;

  typedef enum logic [2:0] {
    CSA_LS_CMD  = 3'b001,
    CSA_LS_DATA = 3'b010,
    CSA_LS_SKIP = 3'b100
  } csa_link_state_type;

  typedef logic [15:0] csa_word_type;

endpackage : csa_pkg

// [src/csa_link_if.sv]
// Signals between the system-clock core and the link-clock port
`timescale 1ns/100ps
`default_nettype none

interface csa_link_if;
  import csa_pkg::*;

  csa_word_type shadow;
  logic         shadow_tgl;
  logic         shadow_ack_tgl;
  logic         read_done_tgl;
  logic         link_rst;

  modport sys  (output shadow, output shadow_tgl, output link_rst,
                input shadow_ack_tgl, input read_done_tgl);
  modport link (input shadow, input shadow_tgl, input link_rst,
                output shadow_ack_tgl, output read_done_tgl);
endinterface : csa_link_if

`default_nettype wire

// [src/csa_link_port.sv]
// Serial status port on the link clock
`timescale 1ns/100ps
`default_nettype none
`include "csa_params.svh"

module csa_link_port
  import csa_pkg::*;
(
  // Link pins
  input  wire logic   link_clk,
  input  wire logic   link_frame_n,
  input  wire logic   sda_in,
  output var  logic   sda_out,
  output var  logic   sda_oe,
  // Core side
  csa_link_if.link    lnk
);

  // ----------------------------------------------------------------
  // Bit order: low byte first, each byte msb first
  // ----------------------------------------------------------------
  function automatic logic word_bit(input csa_word_type w, input logic [4:0] idx);
    logic [7:0] b;
    b = idx[3] ? w[15:8] : w[7:0];
    return b[3'h7 - idx[2:0]];
  endfunction : word_bit

  // ----------------------------------------------------------------
  // Persistent state: shadow handshake and read-done toggle
  // ----------------------------------------------------------------
  logic         tgl_s1, tgl_s2, tgl_seen, done_tgl;
  csa_word_type snap;
  logic         next_tgl_seen, next_done_tgl;
  csa_word_type next_snap;

  // ----------------------------------------------------------------
  // Frame state, cleared whenever the frame is idle
  // ----------------------------------------------------------------
  csa_link_state_type state, next_state;
  logic [4:0]         bitcnt, next_bitcnt;
  logic [7:0]         hdr, next_hdr;
  csa_word_type       outword, next_outword;
  logic               next_sda_oe;

  logic frame_rst;
  assign frame_rst = lnk.link_rst | link_frame_n;

  always_comb begin
    next_tgl_seen = tgl_seen;
    next_snap     = snap;
    next_done_tgl = done_tgl;
    next_state    = state;
    next_bitcnt   = bitcnt;
    next_hdr      = hdr;
    next_outword  = outword;
    next_sda_oe   = 1'b0;
    // Fresh status taken only outside the data phase
    if (tgl_s2 != tgl_seen && state != CSA_LS_DATA) begin
      next_snap     = lnk.shadow;
      next_tgl_seen = tgl_s2;
    end
    unique case (state)
      CSA_LS_CMD: begin
        next_bitcnt = bitcnt + 5'h01;
        next_hdr    = {hdr[6:0], sda_in};
        if (bitcnt == `CSA_HDR_LAST) begin
          next_bitcnt = 5'h00;
          if (sda_in && hdr == `CSA_STATUS_CMD) begin
            // Word sent is the snapshot acknowledged at this edge
            next_state   = CSA_LS_DATA;
            next_outword = next_snap;
            next_sda_oe  = ~word_bit(next_snap, 5'h00);
          end else begin
            // Writes and other commands are ignored
            next_state = CSA_LS_SKIP;
          end
        end
      end
      CSA_LS_DATA: begin
        next_bitcnt = bitcnt + 5'h01;
        if (bitcnt == `CSA_DATA_LAST) begin
          next_done_tgl = ~done_tgl;
          next_state    = CSA_LS_SKIP;
        end else begin
          next_sda_oe = ~word_bit(outword, bitcnt + 5'h01);
        end
      end
      CSA_LS_SKIP: begin
        next_state = CSA_LS_SKIP;
      end
    endcase
  end

  always_ff @(posedge link_clk or posedge lnk.link_rst) begin
    if (lnk.link_rst) begin
      tgl_s1   <= 1'b0;
      tgl_s2   <= 1'b0;
      tgl_seen <= 1'b0;
      snap     <= `CSA_STATUS_RESET;
      done_tgl <= 1'b0;
    end else begin
      tgl_s1   <= lnk.shadow_tgl;
      tgl_s2   <= tgl_s1;
      tgl_seen <= next_tgl_seen;
      snap     <= next_snap;
      done_tgl <= next_done_tgl;
    end
  end

  always_ff @(posedge link_clk or posedge frame_rst) begin
    if (frame_rst) begin
      state   <= CSA_LS_CMD;
      bitcnt  <= 5'h00;
      hdr     <= 8'h00;
      outword <= 16'h0000;
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      state   <= next_state;
      bitcnt  <= next_bitcnt;
      hdr     <= next_hdr;
      outword <= next_outword;
      sda_oe  <= next_sda_oe;
      sda_out <= 1'b0;
    end
  end

  assign lnk.shadow_ack_tgl = tgl_seen;
  assign lnk.read_done_tgl  = done_tgl;

endmodule : csa_link_port

`default_nettype wire

// [sim/csa_top_properties.sv]
// Port checker for the charger status and alert block
`timescale 1ns/100ps
`default_nettype none

module csa_top_properties #(
  parameter int unsigned DEGLITCH_CYCLES = 16
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic por_done,
  input wire logic adapter_present,
  input wire logic drive_regulator_rail,
  input wire logic charger_running,
  input wire logic voltage_loop_active,
  input wire logic charge_inhibit,
  input wire logic link_clk,
  input wire logic link_frame_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic alert_in,
  input wire logic alert_out,
  input wire logic alert_oe
);
  logic [5:0]  pins;
  logic [5:0]  prev_pins;
  int unsigned quiet;
  int unsigned run_calm;
  int unsigned since_frame;

  assign pins = {por_done, adapter_present, drive_regulator_rail,
                 charger_running, voltage_loop_active, charge_inhibit};

  // Cycles since a condition pin moved and since the last frame
  always_ff @(posedge sys_clk) begin
    prev_pins   <= pins;
    quiet       <= (rst || pins != prev_pins) ? 0 : quiet + 1;
    run_calm    <= (rst || pins[2] != prev_pins[2] || pins[0] != prev_pins[0]) ? 0 : run_calm + 1;
    since_frame <= !link_frame_n ? 0 : since_frame + 1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_reset_idle; $fell(rst) |-> !alert_oe; endproperty
  property p_open_drain; !alert_out && !sda_out; endproperty
  property p_idle_release; link_frame_n && $past(link_frame_n) |-> !sda_oe; endproperty
  property p_sda_in_frame; $rose(sda_oe) |-> !link_frame_n; endproperty
  property p_clear_needs_read; $fell(alert_oe) |-> since_frame < 40; endproperty
  property p_alert_cause; $rose(alert_oe) |-> quiet < DEGLITCH_CYCLES + 8; endproperty
  property p_inhibit_alert;
    $rose(charge_inhibit) && charger_running && run_calm > 8 |-> ##[1:6] alert_oe;
  endproperty
  property p_held_low; alert_oe && since_frame > 40 |=> alert_oe; endproperty

  a_reset_idle: assert property (p_reset_idle) else $error("alert active at reset release");
  a_open_drain: assert property (p_open_drain) else $error("open-drain output driven high");
  a_idle_release: assert property (p_idle_release) else $error("data driven outside frame");
  a_sda_in_frame: assert property (p_sda_in_frame) else $error("data drive began idle");
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("alert cleared unread");
  a_alert_cause: assert property (p_alert_cause) else $error("alert without a cause");
  a_inhibit_alert: assert property (p_inhibit_alert) else $error("inhibit not alerted");
  a_held_low: assert property (p_held_low) else $error("alert dropped while idle");

  c_alert_rise: cover property ($rose(alert_oe));
  c_alert_fall: cover property ($fell(alert_oe));
  c_data_drive: cover property ($rose(sda_oe));
endmodule : csa_top_properties

bind csa_top csa_top_properties #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) u_props (.*);

`default_nettype wire

// [sim/csa_host_model.sv]
// Host side of the status link: frames one transfer at a time
`timescale 1ns/100ps
`default_nettype none

module csa_host_model (
  // Link pins
  output var  logic link_clk,
  output var  logic link_frame_n,
  output var  logic host_low,
  input  wire logic sda_wire
);
  initial begin
    link_clk     = 1'b0;
    link_frame_n = 1'b1;
    host_low     = 1'b0;
  end

  // Clock runs only inside the frame
  task automatic xfer(input logic [7:0] cmd, input logic rw, output logic [15:0] word);
    logic [8:0] hdr;
    hdr          = {cmd, rw};
    word         = 16'h0000;
    link_frame_n = 1'b0;
    for (int e = 1; e <= 25; e++) begin
      #31.0;
      host_low = (e <= 9) ? !hdr[9 - e] : 1'b0;
      #31.5;
      if (e >= 10) word[e < 18 ? 17 - e : 33 - e] = sda_wire;
      link_clk = 1'b1;
      #62.5;
      link_clk = 1'b0;
    end
    #62.5;
    link_frame_n = 1'b1;
    #125;
  endtask : xfer
endmodule : csa_host_model

`default_nettype wire

// [sim/charger_status_alert_bench.sv]
// Self-checking bench for the charger status and alert block
`timescale 1ns/100ps
`default_nettype none

module charger_status_alert_bench;
  import csa_pkg::*;
  localparam int unsigned DG = 16;
  logic sys_clk, rst, link_clk, link_frame_n, host_low, sda_out, sda_oe, alert_out, alert_oe;
  logic [5:0]   pins;
  csa_word_type rd;
  int           fails;
  int           total_checks;
  logic [5:0]   corner [5] = '{6'h3e, 6'h3f, 6'h1c, 6'h2e, 6'h36};
  wire logic sda_wire   = !(host_low || (sda_oe && !sda_out));
  wire logic alert_wire = !(alert_oe && !alert_out);

  csa_top #(.DEGLITCH_CYCLES(DG)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .por_done(pins[5]), .adapter_present(pins[4]), .drive_regulator_rail(pins[3]),
    .charger_running(pins[2]), .voltage_loop_active(pins[1]), .charge_inhibit(pins[0]),
    .link_clk(link_clk), .link_frame_n(link_frame_n), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .alert_in(alert_wire),
    .alert_out(alert_out), .alert_oe(alert_oe));
  csa_host_model u_host (.link_clk(link_clk), .link_frame_n(link_frame_n),
    .host_low(host_low), .sda_wire(sda_wire));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic csa_word_type exp_flags(logic [5:0] p);
    logic off;
    off = !p[2] || p[0];
    return {13'h0000, off || !p[1], off, !(p[5] && p[4] && p[3])};
  endfunction : exp_flags

  // Inhibit is seen two edges before the synchronised pins: not-on may pulse
  function automatic logic exp_alert(logic [5:0] old_p, logic [5:0] new_p);
    csa_word_type was_f;
    csa_word_type mid_f;
    was_f = exp_flags(old_p);
    mid_f = exp_flags({old_p[5:1], new_p[0]});
    return (exp_flags(new_p) != was_f) || (mid_f[1] != was_f[1]);
  endfunction : exp_alert

  task automatic check_word(csa_word_type got, csa_word_type exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(logic got, logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: alert %b, expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic read_status(csa_word_type exp);
    u_host.xfer(8'h13, 1'b1, rd);
    check_word(rd, exp);
    tick(2);
    check_bit(alert_oe, 1'b0);
  endtask : read_status

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial begin
    #400000;
    fails++;
    print_verdict();
  end

  initial begin
    csa_word_type nxt;
    logic [5:0]   prev;
    void'($urandom(32'ha3a5));
    rst  = 1'b1;
    pins = 6'h00;
    tick(5);
    rst = 1'b0;
    tick(8);
    check_bit(alert_oe, 1'b0);
    read_status(16'h0007);
    // Corner combinations, then random ones
    for (int i = 0; i < 12; i++) begin
      prev = pins;
      pins = (i < 5) ? corner[i] : 6'($urandom);
      nxt  = exp_flags(pins);
      tick(DG + 12);
      check_bit(alert_oe, exp_alert(prev, pins));
      if (i == 1) begin
        u_host.xfer(8'h12, 1'b1, rd);
        check_word(rd, 16'hffff);
        u_host.xfer(8'h13, 1'b0, rd);
        tick(2);
        check_bit(alert_oe, 1'b1);
      end
      read_status(nxt);
    end
    // Short pulses on deglitched pins
    pins = 6'h3e;
    tick(DG + 12);
    read_status(16'h0000);
    pins = 6'h1c;
    tick(8);
    pins = 6'h3e;
    tick(DG + 12);
    check_bit(alert_oe, 1'b0);
    // Change during a status read leaves the alert set
    fork
      u_host.xfer(8'h13, 1'b1, rd);
      begin
        #1900;
        tick(1);
        pins[0] = 1'b1;
      end
    join
    check_word(rd, 16'h0000);
    tick(2);
    check_bit(alert_oe, 1'b1);
    tick(DG + 12);
    read_status(16'h0006);
    print_verdict();
  end
endmodule : charger_status_alert_bench

`default_nettype wire
